// >>> rtl/fifo_port_pkg.sv
// constants for the parallel fifo port mode control block
`default_nettype none
package fifo_port_pkg;
	localparam int          DATA_W          = 8;
	localparam int          FIFO_DEPTH      = 16;
	// register byte addresses
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_PRESCALE   = 8'h04;
	localparam logic [7:0]  ADDR_TIMEOUT    = 8'h08;
	localparam logic [7:0]  ADDR_TXDATA     = 8'h0c;
	localparam logic [7:0]  ADDR_RXDATA     = 8'h10;
	localparam logic [7:0]  ADDR_STATUS     = 8'h14;
	// control fields
	localparam int          CTRL_MODE_LSB   = 0;
	localparam int          CTRL_WAKE_EN    = 2;
	localparam int          CTRL_PULLDN_EN  = 3;
	localparam int          CTRL_SUSPEND    = 4;
	localparam int          CTRL_POWER_OFF  = 5;
	localparam logic [1:0]  MODE_FIFO       = 2'h0;
	localparam logic [1:0]  MODE_ASYNC_BB   = 2'h1;
	localparam logic [1:0]  MODE_SYNC_BB    = 2'h2;
	// status fields
	localparam int          STAT_RX_VALID   = 0;
	localparam int          STAT_TX_FULL    = 1;
	localparam int          STAT_TX_EMPTY   = 2;
	localparam int          STAT_RESUME     = 3;
	// reset values and timing
	localparam logic [7:0]  TIMEOUT_RST_MS  = 8'h10;
	localparam logic [15:0] PRESCALE_RST    = 16'h0010;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          MS_NS           = 1000000;
	localparam int          CYC_PER_MS      = MS_NS / CLK_PERIOD_NS;
	localparam int          STROBE_CYC      = 2;
endpackage
`default_nettype wire

// >>> rtl/sync_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`default_nettype none
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clocking
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             clkEn,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	// honest flags from the occupancy count
	assign inReady  = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem_q[rdPtr_q];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// storage
	always_ff @(posedge clk) begin
		if (clkEn && push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	// pointers and count
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (clkEn) begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // sync_fifo
`default_nettype wire

// >>> rtl/fifo_port_ctrl.sv
// mode, bit-bang, wake-up, flush timeout and pull-down control of the parallel port
//
// Local design decisions: the register offsets and register access over APB.
`default_nettype none
// How it works
// - bit-bang modes turn the eight data lines into a general I/O port
// - bit-bang bytes leave the fifo one by one, paced by a prescaler timer
// - asynchronous bit-bang drives read and write strobes out on pins
// - synchronous bit-bang samples the pins only when a byte is written out
// - suspended with wake enabled, the receive-available pin becomes an input
// - a low pulse on that pin during suspend raises a resume request
// - flush timeout resets to 16 ms, programmable 1 to 255 ms
// - on timeout, partial received data is flushed to the host
// - power off with option set weakly pulls the data lines low
// - an active-low external reset input resets the block
module fifo_port_ctrl
	import fifo_port_pkg::*;
#(
	parameter int DEPTH       = FIFO_DEPTH,
	parameter int CYC_PER_MS_P = CYC_PER_MS
) (
	// clocking and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              clkEn,
	input  wire logic              extResetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// parallel data lines
	input  wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0]      dataOut,
	output logic [DATA_W-1:0]      dataOe,
	output logic [DATA_W-1:0]      dataPullDn,
	// strobes and handshake pins
	output logic                   bbRdStrobeN,
	output logic                   bbWrStrobeN,
	input  wire logic              rxDataAvailableNIn,
	output logic                   rxDataAvailableNOut,
	output logic                   rxDataAvailableNOe,
	output logic                   powerOnEnableN,
	// usb side events
	output logic                   resumeReq,
	output logic                   flushReq
);
	typedef enum logic [2:0] {
		BB_IDLE   = 3'b001,
		BB_DRIVE  = 3'b010,
		BB_STROBE = 3'b100
	} bb_state_t;

	logic              rstN;
	logic [1:0]        mode_q;
	logic              wakeEn_q;
	logic              pullDnEn_q;
	logic              suspend_q;
	logic              powerOff_q;
	logic [15:0]       prescale_q;
	logic [7:0]        timeoutMs_q;
	logic [15:0]       preCnt_q;
	logic [1:0]        strobeCnt_q;
	bb_state_t         bbState_q;
	logic [DATA_W-1:0] outByte_q;
	logic [DATA_W-1:0] rxByte_q;
	logic              rxValid_q;
	logic              rxPend_q;
	logic [31:0]       msCnt_q;
	logic [7:0]        msElapsed_q;
	logic              wakePinLast_q;
	logic              resume_q;
	logic              flush_q;
	logic              fifoInValid;
	logic              fifoInReady;
	logic              fifoOutValid;
	logic              fifoOutReady;
	logic [DATA_W-1:0] fifoOutData;
	logic              acc;
	logic              wrAcc;
	logic              rdAcc;
	logic              bitBang;
	logic              pinIsInput;
	logic              wakeListen;
	logic [31:0]       rdWord;
	logic              rdErr;

	// reset from either source
	assign rstN = resetn && extResetn;

	function automatic logic addrHit(input logic [7:0] a, input logic [7:0] reg_addr);
		return a == reg_addr;
	endfunction

	assign acc        = psel && penable && pready; // writes land at the answering edge only
	assign wrAcc      = acc && pwrite;
	assign rdAcc      = acc && !pwrite;
	assign bitBang    = (mode_q == MODE_ASYNC_BB) || (mode_q == MODE_SYNC_BB);
	assign pinIsInput = suspend_q && wakeEn_q;
	// listen only once the pin is released, so our own low drive is no wake
	assign wakeListen = pinIsInput && !rxDataAvailableNOe;
	assign fifoInValid  = wrAcc && addrHit(paddr, ADDR_TXDATA);
	assign fifoOutReady = bitBang && (bbState_q == BB_IDLE) && (preCnt_q == '0);

	// bytes from the host wait here for the pacing timer
	sync_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_tx_fifo (
		.clk      (clk),
		.resetn   (rstN),
		.clkEn    (clkEn),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (pwdata[DATA_W-1:0]),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// mode and power control bits
	always_ff @(posedge clk) begin
		if (!rstN) begin
			mode_q     <= MODE_FIFO;
			wakeEn_q   <= 1'b1;
			pullDnEn_q <= 1'b0;
			suspend_q  <= 1'b0;
			powerOff_q <= 1'b0;
		end else if (clkEn && wrAcc && addrHit(paddr, ADDR_CTRL)) begin
			mode_q     <= pwdata[CTRL_MODE_LSB +: 2];
			wakeEn_q   <= pwdata[CTRL_WAKE_EN];
			pullDnEn_q <= pwdata[CTRL_PULLDN_EN];
			suspend_q  <= pwdata[CTRL_SUSPEND];
			powerOff_q <= pwdata[CTRL_POWER_OFF];
		end
	end

	// pacing prescaler and flush timeout
	always_ff @(posedge clk) begin
		if (!rstN) begin
			prescale_q  <= PRESCALE_RST;
			timeoutMs_q <= TIMEOUT_RST_MS;
		end else if (clkEn && wrAcc) begin
			if (addrHit(paddr, ADDR_PRESCALE)) begin
				prescale_q <= pwdata[15:0];
			end else if (addrHit(paddr, ADDR_TIMEOUT) && pwdata[7:0] != 8'h00) begin
				timeoutMs_q <= pwdata[7:0]; // zero ignored
			end
		end
	end

	// register read word and error flag, decoded by address
	always_comb begin
		rdWord = 32'h0000_0000;
		rdErr  = 1'b0;
		if (addrHit(paddr, ADDR_CTRL)) begin
			rdWord = {26'h0, powerOff_q, suspend_q, pullDnEn_q, wakeEn_q, mode_q};
		end else if (addrHit(paddr, ADDR_PRESCALE)) begin
			rdWord = {16'h0, prescale_q};
		end else if (addrHit(paddr, ADDR_TIMEOUT)) begin
			rdWord = {24'h0, timeoutMs_q};
		end else if (addrHit(paddr, ADDR_RXDATA)) begin
			rdWord = {24'h0, rxByte_q};
		end else if (addrHit(paddr, ADDR_STATUS)) begin
			rdWord = {28'h0, resume_q, !fifoOutValid, !fifoInReady, rxValid_q};
		end else if (!addrHit(paddr, ADDR_TXDATA)) begin
			rdErr = 1'b1; // unmapped offset, no effect
		end
	end

	// apb answer: txdata waits while the fifo is full, else one access cycle
	always_ff @(posedge clk) begin
		if (!rstN) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (clkEn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				pready  <= 1'b1;
				prdata  <= rdWord;
				pslverr <= rdErr;
				if (addrHit(paddr, ADDR_TXDATA) && pwrite && !fifoInReady) begin
					pready <= 1'b0; // full fifo stretches the access phase
				end
			end else if (psel && penable && !pready && fifoInReady) begin
				pready <= 1'b1; // stalled txdata write now fits
			end
		end
	end

	// bit-bang pacing and strobe sequencing
	always_ff @(posedge clk) begin
		if (!rstN) begin
			bbState_q   <= BB_IDLE;
			preCnt_q    <= '0;
			strobeCnt_q <= '0;
			outByte_q   <= '0;
			rxPend_q    <= 1'b0;
			bbWrStrobeN <= 1'b1;
			bbRdStrobeN <= 1'b1;
		end else if (clkEn) begin
			rxPend_q <= 1'b0;
			if (preCnt_q != '0) begin
				preCnt_q <= preCnt_q - 1'b1;
			end
			case (bbState_q)
				BB_IDLE: begin
					if (fifoOutReady && fifoOutValid) begin
						outByte_q <= fifoOutData;
						preCnt_q  <= prescale_q;
						bbState_q <= BB_DRIVE;
					end else if (bitBang && mode_q == MODE_ASYNC_BB && preCnt_q == '0) begin
						bbRdStrobeN <= 1'b0; // free-running read
						rxPend_q    <= 1'b1;
						preCnt_q    <= prescale_q;
						strobeCnt_q <= 2'(STROBE_CYC);
						bbState_q   <= BB_STROBE;
					end
				end
				BB_DRIVE: begin
					strobeCnt_q <= 2'(STROBE_CYC);
					bbState_q   <= BB_STROBE;
					if (mode_q == MODE_ASYNC_BB) begin
						bbWrStrobeN <= 1'b0;
					end else begin
						rxPend_q <= 1'b1; // sample tied to this write
					end
				end
				BB_STROBE: begin
					if (strobeCnt_q != '0) begin
						strobeCnt_q <= strobeCnt_q - 1'b1;
					end else begin
						bbWrStrobeN <= 1'b1;
						bbRdStrobeN <= 1'b1;
						bbState_q   <= BB_IDLE;
					end
				end
				default: bbState_q <= BB_IDLE;
			endcase
		end
	end

	// captured pin value returned to the host
	always_ff @(posedge clk) begin
		if (!rstN) begin
			rxByte_q  <= '0;
			rxValid_q <= 1'b0;
		end else if (clkEn) begin
			if (rxPend_q) begin
				rxByte_q  <= dataIn;
				rxValid_q <= 1'b1;
			end else if (rdAcc && addrHit(paddr, ADDR_RXDATA) && pready) begin
				rxValid_q <= 1'b0;
			end
		end
	end

	// data line drive
	always_ff @(posedge clk) begin
		if (!rstN) begin
			dataOut <= '0;
			dataOe  <= '0;
		end else if (clkEn) begin
			dataOut <= bitBang ? outByte_q : '0;
			dataOe  <= (bitBang && !powerOff_q) ? '1 : '0;
		end
	end

	// power-off bleed of the data lines
	always_ff @(posedge clk) begin
		if (!rstN) begin
			dataPullDn <= '0;
		end else if (clkEn) begin
			dataPullDn <= (pullDnEn_q && powerOff_q) ? '1 : '0;
		end
	end

	// receive-available pin role and power enable
	always_ff @(posedge clk) begin
		if (!rstN) begin
			rxDataAvailableNOut <= 1'b1;
			rxDataAvailableNOe  <= 1'b1;
			powerOnEnableN      <= 1'b1;
		end else if (clkEn) begin
			rxDataAvailableNOut <= !rxValid_q;
			rxDataAvailableNOe  <= !pinIsInput;
			powerOnEnableN      <= powerOff_q || suspend_q;
		end
	end

	// wake-up falling edge detection; set wins over status read clear
	always_ff @(posedge clk) begin
		if (!rstN) begin
			wakePinLast_q <= 1'b1;
			resume_q      <= 1'b0;
			resumeReq     <= 1'b0;
		end else if (clkEn) begin
			wakePinLast_q <= wakeListen ? rxDataAvailableNIn : 1'b1;
			resumeReq     <= 1'b0;
			if (wakeListen && wakePinLast_q && !rxDataAvailableNIn) begin
				resumeReq <= 1'b1;
				resume_q  <= 1'b1;
			end else if (rdAcc && addrHit(paddr, ADDR_STATUS) && pready) begin
				resume_q <= 1'b0;
			end
		end
	end

	// flush timer, restarted by each new receive byte
	always_ff @(posedge clk) begin
		if (!rstN) begin
			msCnt_q     <= '0;
			msElapsed_q <= '0;
			flush_q     <= 1'b0;
			flushReq    <= 1'b0;
		end else if (clkEn) begin
			flushReq <= 1'b0;
			if (rxPend_q || !rxValid_q) begin
				msCnt_q     <= '0;
				msElapsed_q <= '0;
				flush_q     <= 1'b0;
			end else if (!flush_q) begin
				if (msCnt_q == 32'(CYC_PER_MS_P - 1)) begin
					msCnt_q <= '0;
					if (msElapsed_q + 8'h01 == timeoutMs_q) begin
						flushReq <= 1'b1;
						flush_q  <= 1'b1;
					end else begin
						msElapsed_q <= msElapsed_q + 8'h01;
					end
				end else begin
					msCnt_q <= msCnt_q + 32'h1;
				end
			end
		end
	end
endmodule // fifo_port_ctrl
`default_nettype wire

// >>> verification/fifo_port_assertions.sv
// checker of the port mode control outputs
`default_nettype none
module fifo_port_checker
	import fifo_port_pkg::*;
(
	// clocking
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic              extResetn,
	// watched ports
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic [DATA_W-1:0] dataOe,
	input wire logic [DATA_W-1:0] dataPullDn,
	input wire logic              bbRdStrobeN,
	input wire logic              bbWrStrobeN,
	input wire logic              rxDataAvailableNOut,
	input wire logic              rxDataAvailableNOe,
	input wire logic              powerOnEnableN,
	input wire logic              resumeReq,
	input wire logic              flushReq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn || !extResetn);
	// bus answer and port pins
	AST_PREADY_ACC: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	AST_OE_GROUP: assert property (dataOe == 8'h00 || dataOe == 8'hff)
		else $error("data lines split");
	AST_WR_LEN: assert property ($fell(bbWrStrobeN) |-> !bbWrStrobeN[*3] ##1 bbWrStrobeN)
		else $error("write strobe length");
	AST_RD_LEN: assert property ($fell(bbRdStrobeN) |-> !bbRdStrobeN[*3] ##1 bbRdStrobeN)
		else $error("read strobe length");
	AST_RX_INPUT: assert property (!rxDataAvailableNOe |-> powerOnEnableN)
		else $error("rx pin input outside suspend");
	AST_RESUME: assert property (resumeReq |-> !rxDataAvailableNOe && powerOnEnableN)
		else $error("resume without wake input");
	AST_RESUME_PULSE: assert property (resumeReq |=> !resumeReq)
		else $error("resume pulse too long");
	AST_FLUSH: assert property (flushReq |-> !rxDataAvailableNOut ##1 !flushReq)
		else $error("flush without rx data");
	AST_PULLDN: assert property (dataPullDn != 8'h00 |-> dataPullDn == 8'hff && powerOnEnableN)
		else $error("pull-down without power off");
	AST_PULLDN_OE: assert property (dataPullDn != 8'h00 |-> dataOe == 8'h00)
		else $error("pull-down while driving");
	// main scenarios
	cover property (resumeReq);
	cover property (flushReq);
	cover property ($fell(bbWrStrobeN));
	cover property (dataPullDn == 8'hff);
endmodule // fifo_port_checker
bind fifo_port_ctrl fifo_port_checker chk (.clk(clk), .resetn(resetn), .extResetn(extResetn),
	.psel(psel), .penable(penable), .pready(pready), .dataOe(dataOe), .dataPullDn(dataPullDn),
	.bbRdStrobeN(bbRdStrobeN), .bbWrStrobeN(bbWrStrobeN),
	.rxDataAvailableNOut(rxDataAvailableNOut), .rxDataAvailableNOe(rxDataAvailableNOe),
	.powerOnEnableN(powerOnEnableN), .resumeReq(resumeReq), .flushReq(flushReq));
`default_nettype wire

// >>> verification/port_partner.sv
// model of the external logic on the parallel port
`default_nettype none
module port_partner
	import fifo_port_pkg::*;
(
	// clocking
	input wire logic              clk,
	// device pins
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic [DATA_W-1:0] dataOe,
	input wire logic [DATA_W-1:0] dataPullDn,
	input wire logic              bbWrStrobeN,
	input wire logic              rxOut,
	input wire logic              rxOe,
	// bench command
	input wire logic              wakeN,
	// resolved levels
	output logic [DATA_W-1:0]     dataPin,
	output logic                  rxPin,
	output int                    strobeCnt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] flip = 8'h5a;
	// undriven lines toggle, pulled lines read low
	always @(posedge clk) flip <= ~flip;
	assign dataPin = (dataOe & dataOut) | (~dataOe & ~dataPullDn & flip);
	// pulled-up pin, driven low to wake the host
	assign rxPin = rxOe ? rxOut : wakeN;
	// logic clocked by each write strobe
	initial strobeCnt = 0;
	always @(posedge bbWrStrobeN) strobeCnt <= strobeCnt + 1;
endmodule // port_partner
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench of the port mode control block
`default_nettype none
module tb
	import fifo_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, resetn = 0, extResetn = 1, psel = 0, penable = 0, pwrite = 0;
	logic        wakeN = 1, pready, pslverr, err, rdN, wrN, rxOut, rxOe, pwrN, resume, flush;
	logic        rxPin;
	logic [7:0]  paddr = 8'h00, dataPin, dataOut, dataOe, pullDn;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0]  pat [4] = '{8'ha5, 8'h3c, 8'h00, 8'hff};
	int          strobeCnt, num_errors = 0, tests_run = 0, n, n0;
	time         t0;
	fifo_port_ctrl #(.DEPTH(16), .CYC_PER_MS_P(10)) dut (.clk(clk), .resetn(resetn),
		.clkEn(1'b1), .extResetn(extResetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.dataIn(dataPin), .dataOut(dataOut), .dataOe(dataOe), .dataPullDn(pullDn),
		.bbRdStrobeN(rdN), .bbWrStrobeN(wrN), .rxDataAvailableNIn(rxPin),
		.rxDataAvailableNOut(rxOut), .rxDataAvailableNOe(rxOe), .powerOnEnableN(pwrN),
		.resumeReq(resume), .flushReq(flush));
	port_partner far (.clk(clk), .dataOut(dataOut), .dataOe(dataOe), .dataPullDn(pullDn),
		.bbWrStrobeN(wrN), .rxOut(rxOut), .rxOe(rxOe), .wakeN(wakeN), .dataPin(dataPin),
		.rxPin(rxPin), .strobeCnt(strobeCnt));
	// clock
	initial forever #5 clk = ~clk;
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(0, a, 0);
		chk(rd, exp);
	endtask
	// bounded wait for a flag level
	task automatic waitv(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk(s, v);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog
	initial begin
		#400000;
		num_errors++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1;
		rdchk(ADDR_CTRL, 32'h4);
		rdchk(ADDR_PRESCALE, 32'h10);
		rdchk(ADDR_TIMEOUT, 32'h10);
		rdchk(ADDR_STATUS, 32'h4);
		apb(0, 8'h18, 0);
		chk(err, 1);
		wr(ADDR_TIMEOUT, 255);
		rdchk(ADDR_TIMEOUT, 255);
		wr(ADDR_TIMEOUT, 0);
		rdchk(ADDR_TIMEOUT, 255);
		wr(ADDR_TIMEOUT, 1);
		rdchk(ADDR_TIMEOUT, 1);
		$display("registers done");
		// async bit-bang, byte by byte
		wr(ADDR_PRESCALE, 2);
		wr(ADDR_CTRL, MODE_ASYNC_BB);
		foreach (pat[i]) begin
			n0 = strobeCnt;
			wr(ADDR_TXDATA, pat[i]);
			for (n = 0; strobeCnt == n0 && n < 200; n++) @(posedge clk);
			chk(strobeCnt - n0, 1);
			chk(dataPin, pat[i]);
		end
		// fill until full, then paced drain
		wr(ADDR_PRESCALE, 256);
		for (int i = 0; i < 17; i++) wr(ADDR_TXDATA, i);
		apb(0, ADDR_STATUS, 0);
		chk(rd[STAT_TX_FULL], 1);
		t0 = $time;
		for (n0 = 0; !rd[STAT_TX_EMPTY] && n0 < 2000; n0++) apb(0, ADDR_STATUS, 0);
		chk(rd[STAT_TX_EMPTY], 1);
		chk(($time - t0) / 10 >= 15 * 256, 1);
		$display("async bit-bang done");
		// sync bit-bang samples once per write
		wr(ADDR_CTRL, MODE_SYNC_BB);
		wr(ADDR_PRESCALE, 2);
		apb(0, ADDR_RXDATA, 0);
		wr(ADDR_TXDATA, 8'h96);
		waitv(flush, 1);
		rdchk(ADDR_RXDATA, 32'h96);
		repeat (50) @(posedge clk);
		apb(0, ADDR_STATUS, 0);
		chk(rd[STAT_RX_VALID], 0);
		$display("sync bit-bang done");
		// suspend and wake
		wr(ADDR_CTRL, (1 << CTRL_WAKE_EN) | (1 << CTRL_SUSPEND));
		repeat (2) @(posedge clk);
		chk(rxOe, 0);
		chk(pwrN, 1);
		wakeN <= 0;
		waitv(resume, 1);
		wakeN <= 1;
		apb(0, ADDR_STATUS, 0);
		chk(rd[STAT_RESUME], 1);
		wr(ADDR_CTRL, 1 << CTRL_WAKE_EN);
		repeat (2) @(posedge clk);
		chk(rxOe, 1);
		wr(ADDR_CTRL, 1 << CTRL_SUSPEND);
		repeat (2) @(posedge clk);
		chk(rxOe, 1);
		$display("suspend done");
		// power off pull-down
		wr(ADDR_CTRL, (1 << CTRL_PULLDN_EN) | (1 << CTRL_POWER_OFF));
		repeat (2) @(posedge clk);
		chk(pullDn, 8'hff);
		chk(dataPin, 8'h00);
		wr(ADDR_CTRL, 1 << CTRL_POWER_OFF);
		repeat (2) @(posedge clk);
		chk(pullDn, 8'h00);
		$display("pull-down done");
		// external reset restores defaults
		wr(ADDR_TIMEOUT, 9);
		extResetn <= 0;
		repeat (2) @(posedge clk);
		extResetn <= 1;
		rdchk(ADDR_TIMEOUT, 32'h10);
		$display("external reset done");
		stop_test;
	end
endmodule // tb
`default_nettype wire
